// ===== hdl/chip_select_ready_gen.sv
/*
 * Chip-select decoder and wait-state generator with APB registers.
 * Assumes one clock pclk, inputs synchronous to it except the
 * asynchronous ready, and a CPU that starts one bus cycle at a time.
 */
// Contract
// - Physical address is segment shl 4 plus offset
// - Six memory and seven peripheral select outputs
// - Memory selects grouped lower, mid-range, upper
// - Region sizes are software programmable
// - Lower starts at zero, upper ends at top
// - Mid-range start address is programmable
// - Seven adjacent 128-byte blocks above base
// - Peripheral base in memory or I/O space
// - Insert programmed zero to three waits
// - Ready bit may ignore external ready inputs
// - Five ready settings, peripherals split 0-3/4-6
// - 16-bit registers in relocatable 256-byte block
// - External ready synchronised before use
// - Cycle has four clocks, waits after third
// - Two peripheral selects may drive A1, A2
`default_nettype none
module chip_select_ready_gen
	import cs_ready_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// CPU bus-cycle request
	input wire logic cyc_start,
	input wire logic cyc_io,
	input wire logic [15:0] seg_in,
	input wire logic [15:0] off_in,
	output logic cyc_busy,
	output logic cyc_done,
	output logic [19:0] phys_addr,
	output logic reg_block_hit,
	// External side
	input wire logic async_ready_in,
	input wire logic sync_ready_in,
	output logic upper_sel_n,
	output logic lower_sel_n,
	output logic [3:0] mid_sel_n,
	output logic [6:0] per_sel_n
);
	// Control registers
	logic [15:0] upper_ff;
	logic [15:0] lower_ff;
	logic [15:0] mid_base_ff;
	logic [15:0] mid_size_ff;
	logic [15:0] per_base_ff;
	logic [15:0] per_ctl_ff;
	logic [15:0] reloc_ff;
	// Bus-cycle state
	bus_state_e state_ff;
	bus_state_e nxt_state;
	logic [1:0] wait_ff;
	logic use_ext_ff;
	logic [19:0] addr_ff;
	logic [MEM_SEL_N-1:0] msel_ff;
	logic [PER_SEL_N-1:0] psel_ff;
	logic [1:0] lat_a_ff;
	logic done_ff;
	logic hit_ff;
	logic [31:0] rdata_ff;
	// Ready synchronisers
	logic async_ready_in_meta_ff;
	logic async_ready_in_ff;
	logic sync_ready_in_ff;
	// Decode wires
	logic [19:0] nxt_addr;
	logic [9:0] a_hi;
	logic hit_lower;
	logic hit_upper;
	logic hit_mid;
	logic hit_per;
	logic hit_reg;
	logic [9:0] mid_ofs;
	logic [3:0] mid_dec;
	logic [12:0] per_blk;
	logic [6:0] per_dec;
	logic [2:0] nxt_rdy;
	logic ext_ready;
	logic take;
	logic apb_wr;
	logic apb_setup;

	// APB handshakes
	assign apb_wr = psel & penable & pwrite & clk_en;
	assign apb_setup = psel & ~penable & clk_en;
	assign pready = clk_en;
	assign take = clk_en & cyc_start & (state_ff == ST_IDLE);

	// Unmapped offsets answer with an error
	always_comb begin
		if (paddr == OFS_UPPER) begin
			pslverr = 1'b0;
		end else if (paddr == OFS_LOWER || paddr == OFS_MID_BASE) begin
			pslverr = 1'b0;
		end else if (paddr == OFS_MID_SIZE || paddr == OFS_PER_BASE) begin
			pslverr = 1'b0;
		end else if (paddr == OFS_PER_CTL || paddr == OFS_RELOC) begin
			pslverr = 1'b0;
		end else if (paddr == OFS_STATUS) begin
			pslverr = psel & penable & pwrite;
		end else begin
			pslverr = psel & penable;
		end
	end

	// Register writes, 16 bits in the low half
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_ff <= RST_UPPER;
			lower_ff <= RST_LOWER;
			mid_base_ff <= RST_MID_BASE;
			mid_size_ff <= RST_MID_SIZE;
			per_base_ff <= RST_PER_BASE;
			per_ctl_ff <= RST_PER_CTL;
			reloc_ff <= RST_RELOC;
		end else if (apb_wr) begin
			if (paddr == OFS_UPPER) begin
				upper_ff <= pwdata[15:0];
			end else if (paddr == OFS_LOWER) begin
				lower_ff <= pwdata[15:0];
			end else if (paddr == OFS_MID_BASE) begin
				mid_base_ff <= pwdata[15:0];
			end else if (paddr == OFS_MID_SIZE) begin
				mid_size_ff <= pwdata[15:0];
			end else if (paddr == OFS_PER_BASE) begin
				per_base_ff <= pwdata[15:0];
			end else if (paddr == OFS_PER_CTL) begin
				per_ctl_ff <= pwdata[15:0];
			end else if (paddr == OFS_RELOC) begin
				reloc_ff <= pwdata[15:0];
			end
		end
	end

	// Read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= 32'h0;
		end else if (apb_setup) begin
			if (paddr == OFS_UPPER) begin
				rdata_ff <= {16'h0, upper_ff};
			end else if (paddr == OFS_LOWER) begin
				rdata_ff <= {16'h0, lower_ff};
			end else if (paddr == OFS_MID_BASE) begin
				rdata_ff <= {16'h0, mid_base_ff};
			end else if (paddr == OFS_MID_SIZE) begin
				rdata_ff <= {16'h0, mid_size_ff};
			end else if (paddr == OFS_PER_BASE) begin
				rdata_ff <= {16'h0, per_base_ff};
			end else if (paddr == OFS_PER_CTL) begin
				rdata_ff <= {16'h0, per_ctl_ff};
			end else if (paddr == OFS_RELOC) begin
				rdata_ff <= {16'h0, reloc_ff};
			end else if (paddr == OFS_STATUS) begin
				// Live cycle state and ready levels
				rdata_ff <= {16'h0, 6'h0, sync_ready_in_ff, async_ready_in_ff, hit_ff,
					use_ext_ff, wait_ff, 1'b0, state_ff[1:0], state_ff[2]};
			end else begin
				rdata_ff <= 32'h0;
			end
		end
	end
	assign prdata = rdata_ff;

	// Physical address, carry out dropped; I/O uses the offset only
	always_comb begin
		if (cyc_io) begin
			nxt_addr = {4'h0, off_in};
		end else begin
			nxt_addr = 20'({seg_in, 4'h0} + {4'h0, off_in});
		end
	end
	assign a_hi = nxt_addr[19:10];

	// Memory regions in 1K units
	assign hit_lower = ~cyc_io & (a_hi < lower_ff[15:ADR_LSB]);
	assign hit_upper = ~cyc_io & (a_hi >= upper_ff[15:ADR_LSB]);
	assign mid_ofs = 10'(a_hi - mid_base_ff[15:ADR_LSB]);

	// Mid-range split into four equal select blocks
	always_comb begin
		mid_dec = 4'h0;
		hit_mid = 1'b0;
		if (!cyc_io && a_hi >= mid_base_ff[15:ADR_LSB]) begin
			hit_mid = 1'b1;
			if ({1'b0, mid_ofs} < {1'b0, mid_size_ff[15:ADR_LSB]}) begin
				mid_dec = 4'h1;
			end else if ({1'b0, mid_ofs} < 11'({mid_size_ff[15:ADR_LSB], 1'b0})) begin
				mid_dec = 4'h2;
			end else if ({2'b0, mid_ofs} < 12'(3 * mid_size_ff[15:ADR_LSB])) begin
				mid_dec = 4'h4;
			end else if ({2'b0, mid_ofs} < {mid_size_ff[15:ADR_LSB], 2'b0}) begin
				mid_dec = 4'h8;
			end else begin
				hit_mid = 1'b0;
			end
		end
	end

	// Peripheral blocks of 128 bytes above the base
	assign per_blk = 13'((nxt_addr - {per_base_ff[15:ADR_LSB], 10'h0}) >> PER_BLK_LSB);
	always_comb begin
		per_dec = 7'h0;
		hit_per = 1'b0;
		if ((cyc_io != per_base_ff[PER_MEM]) &&
			(nxt_addr >= {per_base_ff[15:ADR_LSB], 10'h0}) &&
			(per_blk < PER_BLK_N)) begin
			hit_per = 1'b1;
			per_dec = 7'(7'h1 << per_blk[2:0]);
		end
	end

	// Register block claims its 256 bytes in the chosen space
	assign hit_reg = (cyc_io != reloc_ff[REL_MEM]) &&
		(nxt_addr[19:8] == reloc_ff[11:0]);

	// Ready setting picked by the decoded area
	always_comb begin
		if (hit_reg) begin
			nxt_rdy = 3'b100;
		end else if (hit_lower) begin
			nxt_rdy = lower_ff[2:0];
		end else if (hit_upper) begin
			nxt_rdy = upper_ff[2:0];
		end else if (hit_mid) begin
			nxt_rdy = mid_size_ff[2:0];
		end else if (hit_per && per_blk[2:0] < PER_HI_FIRST) begin
			nxt_rdy = per_base_ff[2:0];
		end else if (hit_per) begin
			nxt_rdy = per_ctl_ff[2:0];
		end else begin
			nxt_rdy = 3'b000;
		end
	end

	// Async ready through two flops, sync ready through one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_ready_in_meta_ff <= 1'b0;
			async_ready_in_ff <= 1'b0;
			sync_ready_in_ff <= 1'b0;
		end else if (clk_en) begin
			async_ready_in_meta_ff <= async_ready_in;
			async_ready_in_ff <= async_ready_in_meta_ff;
			sync_ready_in_ff <= sync_ready_in;
		end
	end
	assign ext_ready = async_ready_in_ff | sync_ready_in_ff;

	// Bus-cycle sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_state = ST_T1;
				end
			end
			ST_T1: begin
				nxt_state = ST_T2;
			end
			ST_T2: begin
				nxt_state = ST_T3;
			end
			ST_T3, ST_TW: begin
				if (wait_ff != 2'd0) begin
					nxt_state = ST_TW;
				end else if (use_ext_ff && !ext_ready) begin
					nxt_state = ST_TW;
				end else begin
					nxt_state = ST_T4;
				end
			end
			ST_T4: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
		end else if (clk_en) begin
			state_ff <= nxt_state;
		end
	end

	// Wait counter and ready mode, loaded at cycle start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_ff <= 2'd0;
			use_ext_ff <= 1'b0;
		end else if (clk_en) begin
			if (take) begin
				wait_ff <= nxt_rdy[1:0];
				use_ext_ff <= ~nxt_rdy[RDY_IGN];
			end else if ((state_ff == ST_T3 || state_ff == ST_TW) && wait_ff != 2'd0) begin
				wait_ff <= wait_ff - 2'd1;
			end
		end
	end

	// Latched address, selects and register-block flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_ff <= 20'h0;
			msel_ff <= '0;
			psel_ff <= '0;
			lat_a_ff <= 2'b0;
			hit_ff <= 1'b0;
		end else if (clk_en) begin
			if (take) begin
				addr_ff <= nxt_addr;
				lat_a_ff <= nxt_addr[2:1];
				hit_ff <= hit_reg;
				// Priority register block, lower, upper, mid, peripheral
				msel_ff <= '0;
				psel_ff <= '0;
				if (hit_reg) begin
					msel_ff <= '0;
				end else if (hit_lower) begin
					msel_ff <= 6'b000001;
				end else if (hit_upper) begin
					msel_ff <= 6'b000010;
				end else if (hit_mid) begin
					msel_ff <= {mid_dec, 2'b00};
				end else if (hit_per) begin
					psel_ff <= per_dec;
				end
			end else if (state_ff == ST_T4) begin
				msel_ff <= '0;
				psel_ff <= '0;
			end
		end
	end

	// Done pulse in the cycle after T4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_ff <= 1'b0;
		end else if (clk_en) begin
			done_ff <= (state_ff == ST_T4);
		end
	end

	// Active-low outputs; selects 5 and 6 may carry A1 and A2
	assign lower_sel_n = ~msel_ff[0];
	assign upper_sel_n = ~msel_ff[1];
	assign mid_sel_n = ~msel_ff[5:2];
	assign per_sel_n[4:0] = ~psel_ff[4:0];
	assign per_sel_n[5] = per_ctl_ff[PER_ABITS] ? lat_a_ff[0] : ~psel_ff[5];
	assign per_sel_n[6] = per_ctl_ff[PER_ABITS] ? lat_a_ff[1] : ~psel_ff[6];
	assign cyc_busy = (state_ff != ST_IDLE);
	assign cyc_done = done_ff;
	assign phys_addr = addr_ff;
	assign reg_block_hit = hit_ff;
endmodule : chip_select_ready_gen
`default_nettype wire

// ===== hdl/cs_ready_pkg.sv
/*
 * Constants for the chip-select and ready generator: register offsets,
 * field positions, reset values and bus-cycle states.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
`default_nettype none
package cs_ready_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_UPPER = 8'h00;
	localparam logic [7:0] OFS_LOWER = 8'h04;
	localparam logic [7:0] OFS_MID_BASE = 8'h08;
	localparam logic [7:0] OFS_MID_SIZE = 8'h0c;
	localparam logic [7:0] OFS_PER_BASE = 8'h10;
	localparam logic [7:0] OFS_PER_CTL = 8'h14;
	localparam logic [7:0] OFS_RELOC = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	// Field positions
	localparam int ADR_LSB = 6;
	localparam int RDY_IGN = 2;
	localparam int PER_MEM = 3;
	localparam int PER_ABITS = 7;
	localparam int REL_MEM = 12;
	// Reset values
	localparam logic [15:0] RST_UPPER = 16'hffc3;
	localparam logic [15:0] RST_LOWER = 16'h0003;
	localparam logic [15:0] RST_MID_BASE = 16'h0000;
	localparam logic [15:0] RST_MID_SIZE = 16'h0003;
	localparam logic [15:0] RST_PER_BASE = 16'h0003;
	localparam logic [15:0] RST_PER_CTL = 16'h0003;
	localparam logic [15:0] RST_RELOC = 16'h00ff;
	// Geometry
	localparam int MEM_SEL_N = 6;
	localparam int PER_SEL_N = 7;
	localparam int SEG_SHIFT = 4;
	localparam int PER_BLK_LSB = 7;
	localparam logic [12:0] PER_BLK_N = 13'h0007;
	localparam logic [2:0] PER_HI_FIRST = 3'h4;
	// Bus-cycle states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_T1 = 3'b001,
		ST_T2 = 3'b010,
		ST_T3 = 3'b011,
		ST_TW = 3'b100,
		ST_T4 = 3'b101
	} bus_state_e;
endpackage : cs_ready_pkg
`default_nettype wire

// ===== verification/cs_ready_chk.sv
/* Port relations of the chip-select and ready generator.
 * Assumes a bind onto the top module, pclk and presetn as its domain. */
`default_nettype none
module cs_ready_chk
	import cs_ready_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pslverr,
	input wire logic cyc_start,
	input wire logic cyc_busy,
	input wire logic cyc_done,
	input wire logic [19:0] phys_addr,
	input wire logic reg_block_hit,
	input wire logic upper_sel_n,
	input wire logic lower_sel_n,
	input wire logic [3:0] mid_sel_n,
	input wire logic [6:0] per_sel_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// Any select low, the A1/A2 pins left out
	wire logic any_sel = ~&{upper_sel_n, lower_sel_n, mid_sel_n, per_sel_n[4:0]};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_sel_busy: assert property (any_sel |-> cyc_busy)
		else $error("select low outside a bus cycle");
	chk_one_sel: assert property ($onehot0(~{upper_sel_n, lower_sel_n, mid_sel_n, per_sel_n[4:0]}))
		else $error("more than one select low");
	chk_min_len: assert property ($rose(cyc_busy) |-> cyc_busy [*4])
		else $error("bus cycle shorter than four clocks");
	chk_done_end: assert property (cyc_done |-> !cyc_busy && $past(cyc_busy) && !$past(cyc_done))
		else $error("done pulse not at cycle end");
	chk_addr_hold: assert property (cyc_busy && $past(cyc_busy) |-> $stable(phys_addr) && $stable(any_sel))
		else $error("address or select moved in a cycle");
	chk_start_take: assert property (cyc_start && clk_en && !cyc_busy |=> cyc_busy)
		else $error("idle start not taken");
	chk_reg_nosel: assert property (reg_block_hit && cyc_busy |-> !any_sel)
		else $error("select low on register block access");
	chk_ro_status: assert property (psel && penable && pwrite && paddr == OFS_STATUS |-> pslverr)
		else $error("status write not refused");
	chk_unmapped: assert property (psel && penable && paddr > 8'h1f |-> pslverr)
		else $error("unmapped access not refused");
endmodule : cs_ready_chk
`default_nettype wire

// ===== verification/ext_dev.sv
/* External device model: answers ready a set number of cycles after select.
 * Assumes one clock shared with the generator. */
`default_nettype none
module ext_dev (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sel_any,
	input wire logic use_async,
	input wire logic [3:0] lat,
	output logic async_ready_in,
	output logic sync_ready_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_ff; // Cycles selected so far
	logic rdy_ff; // Ready level
	// Count while selected, ready once latency is reached
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 4'h0;
			rdy_ff <= 1'b0;
		end else if (!sel_any) begin // Deselected: ready drops
			cnt_ff <= 4'h0;
			rdy_ff <= 1'b0;
		end else begin
			cnt_ff <= (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
			rdy_ff <= (cnt_ff >= lat);
		end
	end
	// Ready on one line only, the other held low
	assign async_ready_in = use_async & rdy_ff;
	assign sync_ready_in = ~use_async & rdy_ff;
endmodule : ext_dev
`default_nettype wire

// ===== verification/testbench.sv
/* Self-checking bench for the chip-select and ready generator.
 * Assumes the checker and device model files are compiled first. */
`default_nettype none
module testbench
	import cs_ready_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic cyc_start = 0, cyc_io = 0, use_async = 0;
	logic [15:0] seg_in = 0, off_in = 0;
	logic [3:0] lat = 0; // Device answer latency
	wire logic [31:0] prdata;
	wire logic pready, pslverr, cyc_busy, cyc_done, reg_block_hit;
	wire logic async_ready_in, sync_ready_in, upper_sel_n, lower_sel_n;
	wire logic [19:0] phys_addr;
	wire logic [3:0] mid_sel_n;
	wire logic [6:0] per_sel_n;
	wire logic sel_any = ~&{upper_sel_n, lower_sel_n, mid_sel_n, per_sel_n};
	int miscompares = 0, samples_checked = 0, seed = 8606, n;
	logic [31:0] rd; // Last read data
	logic err; // Last error response
	localparam logic [15:0] RV [7] = '{RST_UPPER, RST_LOWER, RST_MID_BASE, RST_MID_SIZE,
		RST_PER_BASE, RST_PER_CTL, RST_RELOC};
	chip_select_ready_gen uut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cyc_start, .cyc_io, .seg_in, .off_in, .cyc_busy,
		.cyc_done, .phys_addr, .reg_block_hit, .async_ready_in, .sync_ready_in, .upper_sel_n,
		.lower_sel_n, .mid_sel_n, .per_sel_n);
	ext_dev dev (.pclk, .presetn, .sel_any, .use_async, .lat, .async_ready_in, .sync_ready_in);
	// Expected address: I/O is the bare offset, carry dropped
	function automatic logic [19:0] exp_addr(input logic io, input logic [15:0] s, input logic [15:0] o);
		return io ? {4'h0, o} : {s, 4'h0} + {4'h0, o};
	endfunction : exp_addr
	// Compare and count
	task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// One APB transfer, upper data bits random
	task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'($random(seed)), d};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1 && n < 20);
		if (pready !== 1) begin
			miscompares++;
			$display("[ERR] pready expected 1 seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// One bus cycle: address, selects, length window, done pulse
	task automatic cyc(input logic io, input logic [15:0] s, input logic [15:0] o,
		input logic [12:0] es, input int lo, input int hi);
		@(posedge pclk);
		cyc_start <= 1;
		cyc_io <= io;
		seg_in <= s;
		off_in <= o;
		@(posedge pclk);
		cyc_start <= 0;
		#1;
		check("phys_addr", exp_addr(io, s, o), phys_addr);
		check("selects", 20'(es), {7'h0, upper_sel_n, lower_sel_n, mid_sel_n, per_sel_n});
		n = 0;
		while (cyc_busy === 1 && n < 40) begin
			n++;
			@(posedge pclk);
			#1;
		end
		check("cyc_done", 20'h1, {19'h0, cyc_done});
		check("cycle length", 20'h1, {19'h0, n >= lo && n <= hi});
	endtask : cyc
	// Counts, verdict and end of run
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	// Clock
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	// Hang guard
	initial begin
		#100000;
		miscompares++;
		results();
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 7; i++) begin
			apb(0, 8'(4 * i), 16'h0);
			check("reset value", {4'h0, RV[i]}, rd[19:0]);
		end
		apb(0, 8'h40, 16'h0);
		check("unmapped err", 20'h1, {19'h0, err});
		apb(1, OFS_STATUS, 16'hffff);
		check("status err", 20'h1, {19'h0, err});
		// Default top area: three waits, then slow or quick device
		lat <= 10;
		cyc(0, 16'hfff0, 16'($random(seed)) & 16'h00ff, 13'h0fff, 11, 16);
		use_async <= 1;
		lat <= 0;
		cyc(0, 16'hffc0, 16'($random(seed)) & 16'h03ff, 13'h0fff, 7, 9);
		// Lower area, ready ignored while device never answers
		use_async <= 0;
		lat <= 15;
		for (int w = 0; w < 4; w++) begin
			apb(1, OFS_LOWER, 16'h0404 | 16'(w));
			cyc(0, 16'($random(seed)) & 16'h03f0, 16'($random(seed)) & 16'hf, 13'h17ff, 4 + w, 4 + w);
		end
		cyc(0, 16'hffff, 16'h0020, 13'h17ff, 7, 7);
		// Mid-range, four 1K selects above a moved base
		apb(1, OFS_MID_BASE, 16'h0800);
		apb(1, OFS_MID_SIZE, 16'h0044);
		apb(0, OFS_MID_SIZE, 16'h0);
		check("mid size readback", 20'h00044, rd[19:0]);
		check("upper half", 20'h0, {4'h0, rd[31:16]});
		for (int k = 0; k < 4; k++)
			cyc(0, 16'h0800 + 16'(k * 64), 16'($random(seed)) & 16'h03ff, ~(13'h0080 << k), 4, 4);
		// Peripheral blocks in I/O space, two ready groups
		apb(1, OFS_PER_BASE, 16'h0044);
		apb(1, OFS_PER_CTL, 16'h0006);
		for (int k = 0; k < 7; k++)
			cyc(1, 16'($random(seed)), 16'h0400 + 16'(k * 128) + (16'($random(seed)) & 16'h7f),
				~(13'h1 << k), k < 4 ? 4 : 6, k < 4 ? 4 : 6);
		// Selects 5 and 6 carry latched A1, A2
		apb(1, OFS_PER_CTL, 16'h0086);
		cyc(1, 16'($random(seed)), 16'h0404, 13'h1fde, 4, 4);
		apb(1, OFS_PER_CTL, 16'h0006);
		// Peripheral base moved into memory space
		apb(1, OFS_LOWER, 16'h0004);
		apb(1, OFS_PER_BASE, 16'h004c);
		cyc(0, 16'h0040, 16'h0010, ~13'h1, 4, 4);
		// Register block: no select, no waits
		cyc(1, 16'h1234, 16'hff00 | (16'($random(seed)) & 16'hff), 13'h1fff, 4, 4);
		check("reg hit", 20'h1, {19'h0, reg_block_hit});
		results();
	end
endmodule : testbench
bind chip_select_ready_gen cs_ready_chk u_chk (.pclk, .presetn, .clk_en, .psel, .penable,
	.pwrite, .paddr, .pslverr, .cyc_start, .cyc_busy, .cyc_done, .phys_addr, .reg_block_hit,
	.upper_sel_n, .lower_sel_n, .mid_sel_n, .per_sel_n);
`default_nettype wire
